// file: design/icache_err_regs.svh
// register offsets, field positions, reset values and codes of the error-action block
`ifndef ICACHE_ERR_REGS_SVH
`define ICACHE_ERR_REGS_SVH
`define WAY_N 4
`define SET_W 6
// register byte offsets
`define CSR1_OFF 8'h00
`define SWINV_OFF 8'h04
`define STAT_OFF 8'h08
// cache_control_status_1 fields
`define EA_LSB 0
`define EDT_LSB 2
`define ECE_BIT 4
`define CSR1_RST 32'h0000_0000
`define EA_MCHK 2'h0
`define EA_CORR 2'h1
`define DT_PAR 2'h0
`define DT_EDC 2'h1
// set_way_invalidate_cmd fields
`define FW_WAY_LSB 24
`define FW_SET_LSB 5
`define FW_CMD_LSB 0
`define SWINV_RST 32'h0000_0000
`define CMD_INV 2'h0
`define CMD_PTR 2'h3
// status fields
`define ST_MC 0
`define ST_CORR 1
`define ST_BUSY 2
`define ST_PTR_LSB 4
// bus responses
`define RESP_OK 2'h0
`define RESP_SLV 2'h2
`endif

// file: design/icache_err_pkg.sv
// types shared by the error-action block and its users
`include "icache_err_regs.svh"
package icache_err_pkg;
  typedef logic [`WAY_N-1:0] way_vec_t;
  // kind of lookup presented by the fetch and cache-management pipeline
  typedef enum logic [2:0] {OP_FETCH, OP_TOUCH, OP_LINE_INV, OP_TOUCH_LOCK, OP_LOCK_CLEAR} op_t;
  // one lookup with its per-way check results
  typedef struct packed {
    op_t op;              // operation kind
    logic cacheable;      // low when inhibit_attribute is set
    way_vec_t hit;        // tag match per way
    way_vec_t tag_err;    // tag check error per way
    way_vec_t tag_single; // tag error is single-bit
    way_vec_t lock;       // lock bit per way
    way_vec_t lock_err;   // lock bit itself in error
    way_vec_t data_err;   // requested double word in error
  } lookup_t;
  // one decided action, valid for one cycle
  typedef struct packed {
    logic valid;       // action present
    logic mchk;        // raise machine check
    logic relookup;    // repeat the lookup after correction
    logic serve_hit;   // deliver from the cache
    logic single_beat; // bypass cache, single-beat bus transfer
    logic nop;         // operation dropped silently
    way_vec_t fix;     // rewrite corrected tag
    way_vec_t inval;   // clear valid, lock bit untouched
    way_vec_t lock_set;
    way_vec_t lock_clr;
    logic refill;      // start a line refill
    logic [1:0] refill_way;
    logic refill_keep; // same line, keep lock, pointer held
  } action_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CORR, ST_FILL} state_t;
endpackage

// file: design/icache_err_action.sv
// error-action decision logic of the instruction cache lookup path
`timescale 1ns/1ps
`include "icache_err_regs.svh"
// Behaviour
// [RQ1] check-policy: tag error on cacheable lookup, machine check
// [RQ2] check-policy: hit with data error, machine check
// [RQ3] inhibited lookup with error: single beat, silent
// [RQ4] correction policy: tag error inserts correction cycle
// [RQ5] detection code: fix single-bit tags, invalidate others
// [RQ6] parity: no repair, invalidate every errored tag
// [RQ7] locked line invalidated: machine check, no replacement
// [RQ8] re-lookup data error: refill same line, pointer held
// [RQ9] clean re-lookup hit: ignore other data errors
// [RQ10] locked refill bus error: machine check, invalidate
// [RQ11] checking disabled: never signal any error
// [RQ12] set/way invalidate: always invalidate, report nothing
// [RQ13] touch with any error: silent no-op
// [RQ14] line invalidate hit clean/unlocked: invalidate, quiet
// [RQ15] line invalidate correction: fix, drop unlocked, quiet
// [RQ16] line invalidate locked errored hit or miss: untouched
// [RQ17] lock ops clean hit: set/clear lock, quiet
// [RQ18] touch-lock miss: machine check per policy
// [RQ19] lock-clear miss: machine check only for locked
// [RQ20] inhibited, no correction: tag error is a miss
// [RQ21] inhibited clean hit served from cache
// [RQ22] inhibited errored hit: miss, correct if unlocked
module icache_err_action (
  input wire logic ref_clk, // core clock, 250 MHz
  input wire logic reset_n, // async reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic lk_valid, // lookup result presented
  output logic lk_ready, // lookup accepted this cycle
  input wire icache_err_pkg::lookup_t lk, // lookup result
  output icache_err_pkg::action_t act, // decided action, one cycle
  input wire logic fill_done, // refill finished
  input wire logic fill_bus_err, // refill ended with bus error
  output logic swinv_valid, // set/way invalidate pulse
  output logic [1:0] swinv_way, // way to invalidate
  output logic [`SET_W-1:0] swinv_set, // set to invalidate
  output logic [1:0] repl_ptr // replacement pointer
);
  localparam int W = `WAY_N;
  // control and status storage
  logic [31:0] csr1_q, csr1_d; // cache_control_status_1
  logic [31:0] swreg_q, swreg_d; // set_way_invalidate_cmd image
  logic mc_seen_q, corr_seen_q; // sticky status
  logic [1:0] ptr_q; // replacement pointer
  icache_err_pkg::state_t st_q, st_d; // sequencer state
  icache_err_pkg::action_t act_q, act_d, fill_a; // action register
  logic [1:0] fway_q; // way under refill
  logic fkeep_q; // refill keeps lock and pointer
  // bus slave holding registers
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic [1:0] rresp_q, bresp_q;

  // decoded control fields
  wire [1:0] ea = csr1_q[`EA_LSB +: 2];
  wire [1:0] dt = csr1_q[`EDT_LSB +: 2];
  wire ece = csr1_q[`ECE_BIT];
  wire corr = (ea == `EA_CORR);
  wire edc = (dt == `DT_EDC);
  wire taken = lk_valid & lk_ready;

  // checking disabled masks the tag and data error reports at the source
  wire [W-1:0] te = lk.tag_err & {W{ece}}; // RQ11
  wire [W-1:0] de = lk.data_err & {W{ece}}; // RQ11
  logic [W-1:0] fixable, unc, hc, hcd;
  // per-way classification of the lookup
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_way
      assign fixable[g] = te[g] & lk.tag_single[g] & edc; // RQ5 RQ6
      assign unc[g] = te[g] & ~fixable[g]; // RQ5 RQ6
      assign hc[g] = lk.hit[g] & ~te[g];
      assign hcd[g] = hc[g] & de[g];
    end
  endgenerate
  wire any_te = |te;
  wire any_hc = |hc;
  wire hit_derr = |hcd;
  wire any_lock = |lk.lock;
  wire unc_lock = |(unc & lk.lock);
  wire unc_lk2 = |(unc & (lk.lock | lk.lock_err));
  wire te_lock = |(te & lk.lock);

  // first clean hit way and replacement victim (first unlocked from pointer)
  logic [1:0] hit_way, victim;
  logic victim_ok;
  always_comb begin
    hit_way = 2'h0;
    victim = 2'h0;
    victim_ok = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (hc[i]) begin
        hit_way = 2'(i);
      end
    end
    for (int k = W - 1; k >= 0; k--) begin
      if (!lk.lock[2'(ptr_q + 2'(k))]) begin
        victim = 2'(ptr_q + 2'(k));
        victim_ok = 1'b1;
      end
    end
  end

  // the policy decision for one accepted lookup
  logic go_corr, go_fill;
  always_comb begin
    act_d = '0;
    act_d.valid = 1'b1;
    go_corr = 1'b0;
    go_fill = 1'b0;
    case (lk.op)
      icache_err_pkg::OP_FETCH: begin
        if (!lk.cacheable) begin
          if (corr && any_te && !any_lock) begin
            act_d.fix = fixable; // RQ22
            act_d.inval = unc; // RQ22
            act_d.relookup = 1'b1;
            go_corr = 1'b1;
          end else if (any_hc && !hit_derr) begin
            act_d.serve_hit = 1'b1; // RQ21
          end else begin
            act_d.single_beat = 1'b1; // RQ3 RQ20 RQ22
          end
        end else if (!corr) begin
          if (any_te || hit_derr) begin
            act_d.mchk = 1'b1; // RQ1 RQ2
          end else if (any_hc) begin
            act_d.serve_hit = 1'b1;
          end else if (victim_ok) begin
            act_d.refill = 1'b1;
            act_d.refill_way = victim;
            go_fill = 1'b1;
          end else begin
            act_d.single_beat = 1'b1;
          end
        end else if (any_te) begin
          act_d.fix = fixable; // RQ4 RQ5
          act_d.inval = unc; // RQ5 RQ6
          act_d.mchk = unc_lock; // RQ7
          act_d.relookup = !unc_lock; // RQ7
          go_corr = !unc_lock;
        end else if (hit_derr) begin
          act_d.refill = 1'b1; // RQ8
          act_d.refill_way = hit_way;
          act_d.refill_keep = 1'b1;
          go_fill = 1'b1;
        end else if (any_hc) begin
          act_d.serve_hit = 1'b1; // RQ9
        end else if (victim_ok) begin
          act_d.refill = 1'b1;
          act_d.refill_way = victim;
          go_fill = 1'b1;
        end else begin
          act_d.single_beat = 1'b1;
        end
      end
      icache_err_pkg::OP_TOUCH: begin
        if (any_te || hit_derr || !lk.cacheable) begin
          act_d.nop = 1'b1; // RQ13
        end else if (any_hc) begin
          act_d.serve_hit = 1'b1;
        end else if (victim_ok) begin
          act_d.refill = 1'b1;
          act_d.refill_way = victim;
          go_fill = 1'b1;
        end else begin
          act_d.nop = 1'b1;
        end
      end
      icache_err_pkg::OP_LINE_INV: begin
        if (corr && any_te) begin
          act_d.fix = fixable; // RQ15
          act_d.inval = unc & ~lk.lock; // RQ15
          act_d.relookup = 1'b1;
          go_corr = 1'b1;
        end else begin
          // locked errored hits stay, misses touch nothing
          act_d.inval = lk.hit & ~(te & lk.lock); // RQ14 RQ16
        end
      end
      icache_err_pkg::OP_TOUCH_LOCK, icache_err_pkg::OP_LOCK_CLEAR: begin
        if (!lk.cacheable) begin
          act_d.nop = 1'b1;
        end else if (any_hc) begin
          if (lk.op == icache_err_pkg::OP_TOUCH_LOCK) begin
            act_d.lock_set = hc; // RQ17
          end else begin
            act_d.lock_clr = hc; // RQ17
          end
          act_d.inval = corr ? (unc & ~lk.lock) : '0; // RQ17
        end else if (!corr) begin
          // check policy: the two lock ops differ in what counts
          act_d.mchk = (lk.op == icache_err_pkg::OP_TOUCH_LOCK) ? any_te : te_lock; // RQ18 RQ19
        end else begin
          act_d.inval = unc; // RQ18 RQ19
          act_d.mchk = (lk.op == icache_err_pkg::OP_TOUCH_LOCK) ? unc_lock : unc_lk2; // RQ18 RQ19
        end
      end
      default: begin
        act_d.nop = 1'b1;
      end
    endcase
  end

  // end of refill: a bus error on a kept locked line is fatal
  always_comb begin
    fill_a = '0;
    fill_a.valid = fill_bus_err;
    fill_a.inval[fway_q] = fill_bus_err; // RQ10
    fill_a.mchk = fill_bus_err & fkeep_q; // RQ10
  end

  // sequencer next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      icache_err_pkg::ST_IDLE: begin
        if (taken && go_corr) begin
          st_d = icache_err_pkg::ST_CORR;
        end else if (taken && go_fill) begin
          st_d = icache_err_pkg::ST_FILL;
        end
      end
      icache_err_pkg::ST_CORR: st_d = icache_err_pkg::ST_IDLE; // tag rewrite cycle
      icache_err_pkg::ST_FILL: begin
        if (fill_done) begin
          st_d = icache_err_pkg::ST_IDLE;
        end
      end
      default: st_d = icache_err_pkg::ST_IDLE;
    endcase
  end
  assign lk_ready = (st_q == icache_err_pkg::ST_IDLE);

  // sequencer, action register and refill bookkeeping
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= icache_err_pkg::ST_IDLE;
      act_q <= '0;
      fway_q <= 2'h0;
      fkeep_q <= 1'b0;
    end else begin
      st_q <= st_d;
      act_q <= taken ? act_d : ((st_q == icache_err_pkg::ST_FILL && fill_done) ? fill_a : '0);
      if (taken && go_fill) begin
        fway_q <= act_d.refill_way;
        fkeep_q <= act_d.refill_keep;
      end
    end
  end
  assign act = act_q;

  // bus write path: address and data are latched independently
  wire aw_hs = awvalid & awready;
  wire w_hs = wvalid & wready;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  wire wr_csr1 = wr_go & (aw_addr_q == `CSR1_OFF);
  wire wr_sw = wr_go & (aw_addr_q == `SWINV_OFF);
  wire wr_stat = wr_go & (aw_addr_q == `STAT_OFF);
  wire wr_hit = wr_csr1 | wr_sw | wr_stat;
  assign awready = ~aw_have_q;
  assign wready = ~w_have_q;
  assign csr1_d = (csr1_q & ~wmask) | (w_data_q & wmask);
  assign swreg_d = (swreg_q & ~wmask) | (w_data_q & wmask);
  wire [1:0] sw_cmd = swreg_d[`FW_CMD_LSB +: 2];
  wire sw_inv = wr_sw & (sw_cmd == `CMD_INV);
  wire sw_ptr = wr_sw & (sw_cmd == `CMD_PTR);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OK;
    end else begin
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end else if (wr_go) begin
        aw_have_q <= 1'b0;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end else if (wr_go) begin
        w_have_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `RESP_OK : `RESP_SLV;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // control registers, invalidate command and pointer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      csr1_q <= `CSR1_RST;
      swreg_q <= `SWINV_RST;
      swinv_valid <= 1'b0;
      swinv_way <= 2'h0;
      swinv_set <= '0;
      ptr_q <= 2'h0;
    end else begin
      if (wr_csr1) begin
        csr1_q <= csr1_d;
      end
      if (wr_sw) begin
        swreg_q <= swreg_d;
      end
      // no tag match and no error report for this path
      swinv_valid <= sw_inv; // RQ12
      if (sw_inv) begin
        swinv_way <= swreg_d[`FW_WAY_LSB +: 2]; // RQ12
        swinv_set <= swreg_d[`FW_SET_LSB +: `SET_W];
      end
      // software load beats the advance after a clean normal fill
      if (sw_ptr) begin
        ptr_q <= swreg_d[`FW_WAY_LSB +: 2];
      end else if (st_q == icache_err_pkg::ST_FILL && fill_done && !fill_bus_err && !fkeep_q) begin
        ptr_q <= fway_q + 2'h1; // RQ8
      end
    end
  end
  assign repl_ptr = ptr_q;

  // sticky status: a new event wins over a same-cycle clear
  wire [31:0] w1c = w_data_q & wmask;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mc_seen_q <= 1'b0;
      corr_seen_q <= 1'b0;
    end else begin
      mc_seen_q <= act_q.mchk | (mc_seen_q & ~(wr_stat & w1c[`ST_MC]));
      corr_seen_q <= (|act_q.fix) | (|act_q.inval) | (corr_seen_q & ~(wr_stat & w1c[`ST_CORR]));
    end
  end

  // bus read path, one cycle from address to data
  logic [31:0] stat_v;
  always_comb begin
    stat_v = 32'h0000_0000;
    stat_v[`ST_MC] = mc_seen_q;
    stat_v[`ST_CORR] = corr_seen_q;
    stat_v[`ST_BUSY] = (st_q != icache_err_pkg::ST_IDLE);
    stat_v[`ST_PTR_LSB +: 2] = ptr_q;
  end
  wire rd_csr1 = (araddr == `CSR1_OFF);
  wire rd_sw = (araddr == `SWINV_OFF);
  wire rd_stat = (araddr == `STAT_OFF);
  wire [31:0] rd_mux = rd_csr1 ? csr1_q : (rd_sw ? swreg_q : (rd_stat ? stat_v : 32'h0000_0000));
  assign arready = ~rvalid_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OK;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= (rd_csr1 | rd_sw | rd_stat) ? `RESP_OK : `RESP_SLV;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // checks on the decided actions and the replacement pointer
  wire cfetch = taken & (lk.op == icache_err_pkg::OP_FETCH) & lk.cacheable;
  a_chk_off_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    taken && !ece |=> !act.mchk && act.fix == '0) // RQ11
    else $error("error signalled with checking disabled");
  a_mchk_tag_err: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfetch && !corr && any_te |=> act.mchk && !act.serve_hit) // RQ1
    else $error("tag error did not raise machine check");
  a_mchk_data_err: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfetch && !corr && hit_derr |=> act.mchk) // RQ2
    else $error("data error hit did not raise machine check");
  a_inhib_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    taken && lk.op == icache_err_pkg::OP_FETCH && !lk.cacheable
    |=> !act.mchk && (act.single_beat || act.serve_hit || act.relookup)) // RQ3
    else $error("inhibited fetch misbehaved");
  a_corr_insert: assert property (@(posedge ref_clk) disable iff (!reset_n)
    cfetch && corr && any_te && !unc_lock |=> act.relookup && !lk_ready ##1 lk_ready) // RQ4
    else $error("correction cycle not inserted");
  a_parity_no_fix: assert property (@(posedge ref_clk) disable iff (!reset_n)
    taken && !edc |=> act.fix == '0) // RQ6
    else $error("tag repaired under parity");
  a_touch_silent: assert property (@(posedge ref_clk) disable iff (!reset_n)
    taken && lk.op == icache_err_pkg::OP_TOUCH && (any_te || hit_derr)
    |=> act.nop && !act.mchk && act.inval == '0) // RQ13
    else $error("touch with error not silent");
  a_lineinv_no_mc: assert property (@(posedge ref_clk) disable iff (!reset_n)
    taken && lk.op == icache_err_pkg::OP_LINE_INV |=> !act.mchk) // RQ14
    else $error("line invalidate raised machine check");
  a_keep_ptr_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == icache_err_pkg::ST_FILL && fkeep_q && fill_done && !sw_ptr
    |=> $stable(repl_ptr)) // RQ8
    else $error("pointer moved on same-line refill");
  a_bus_err_lock: assert property (@(posedge ref_clk) disable iff (!reset_n)
    st_q == icache_err_pkg::ST_FILL && fkeep_q && fill_done && fill_bus_err
    |=> act.mchk && act.inval[fway_q] && act.lock_clr == '0) // RQ10
    else $error("locked refill bus error not reported");
  c_corr_cycle: cover property (@(posedge ref_clk) disable iff (!reset_n)
    cfetch && corr && any_te ##1 act.relookup);
  c_same_refill: cover property (@(posedge ref_clk) disable iff (!reset_n)
    act.refill && act.refill_keep);
  c_lock_mchk: cover property (@(posedge ref_clk) disable iff (!reset_n)
    act.mchk && act.inval != '0);
endmodule

// file: dv/fetch_partner.sv
// fetch unit and refill path model facing the lookup side
`timescale 1ns/1ps
module fetch_partner (
  input wire logic ref_clk, // core clock
  input wire logic lk_ready, // lookup taken when high
  input wire icache_err_pkg::action_t act, // decided action
  output icache_err_pkg::lookup_t lk, // lookup result
  output logic lk_valid, // lookup valid
  output logic fill_done, // refill end pulse
  output logic fill_bus_err // refill bus error
);
  initial {lk_valid, lk, fill_done, fill_bus_err} = '0; // quiet until used
  // hold a lookup until taken; a released payload is scrambled, never left stale
  task automatic send(input icache_err_pkg::lookup_t l, output icache_err_pkg::action_t a);
    logic rd;
    @(posedge ref_clk);
    lk <= l;
    lk_valid <= 1'h1;
    forever begin
      @(negedge ref_clk);
      rd = lk_ready; // ready is steady mid-cycle
      @(posedge ref_clk);
      if (rd) break;
    end
    lk_valid <= 1'h0;
    lk <= ~l;
    #1 a = act;
  endtask
  // end a refill after some cycles, with or without a bus error
  task automatic fill(input int dl, input logic e, output icache_err_pkg::action_t a);
    repeat (dl) @(posedge ref_clk);
    fill_done <= 1'h1;
    fill_bus_err <= e;
    @(posedge ref_clk);
    fill_done <= 1'h0;
    fill_bus_err <= ~e; // qualifier is junk outside the pulse
    #1 a = act;
  endtask
endmodule

// file: dv/tb_icache_err_action.sv
// self-checking bench for the error-action block
`timescale 1ns/1ps
module tb_icache_err_action;
  logic ref_clk, reset_n, awvalid, wvalid, bready, arvalid, rready; // clock, reset, master
  logic awready, wready, bvalid, arready, rvalid, lk_valid, lk_ready; // handshakes
  logic fill_done, fill_bus_err, swinv_valid, sv; // refill, invalidate pulse
  logic [7:0] awaddr, araddr, seed, sw, swq[$]; // addresses, random state, way/set
  logic [31:0] wdata, rdata, d; // data
  logic [3:0] wstrb; // strobes, all bytes
  logic [1:0] bresp, rresp, swinv_way, repl_ptr, r; // responses, way, pointer
  logic [5:0] swinv_set; // invalidated set
  icache_err_pkg::lookup_t lk; // lookup bus
  icache_err_pkg::action_t act, a, b; // actions
  int n_mismatch, samples_checked, pol, dt, ce; // counts, model settings
  icache_err_action uut (.ref_clk(ref_clk), .reset_n(reset_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .lk_valid(lk_valid), .lk_ready(lk_ready), .lk(lk), .act(act),
    .fill_done(fill_done), .fill_bus_err(fill_bus_err), .swinv_valid(swinv_valid),
    .swinv_way(swinv_way), .swinv_set(swinv_set), .repl_ptr(repl_ptr));
  fetch_partner p (.ref_clk(ref_clk), .lk_ready(lk_ready), .act(act), .lk(lk),
    .lk_valid(lk_valid), .fill_done(fill_done), .fill_bus_err(fill_bus_err));
  // 250 MHz core clock
  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", nm, e, s);
    end
  endtask
  // counts, verdict, end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one bus access; each channel released only at the edge that takes it
  task automatic bus(input logic we, input logic [7:0] ad, input logic [31:0] v);
    logic ta, tw, rv;
    @(posedge ref_clk);
    {awaddr, araddr, wdata} <= {ad, ad, v};
    {awvalid, wvalid, bready, arvalid, rready} <= {we, we, we, !we, !we};
    forever begin
      @(negedge ref_clk);
      ta = (awready & awvalid) | (arready & arvalid);
      tw = wready & wvalid;
      rv = we ? bvalid : rvalid;
      r = we ? bresp : rresp;
      d = rdata;
      sv = swinv_valid; // pulse lines up with the write response
      sw = {swinv_set, swinv_way};
      @(posedge ref_clk);
      if (ta) {awvalid, arvalid} <= 2'h0;
      if (tw) wvalid <= 1'h0;
      if (rv) break;
    end
    {bready, rready} <= 2'h0;
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected {mchk, relookup, nop, single_beat, serve_hit, inval, fix}
  function automatic logic [12:0] model(icache_err_pkg::lookup_t l);
    logic m, rl, n, s, h;
    icache_err_pkg::way_vec_t te, de, cl, iv, fx;
    {m, rl, n, s, iv} = '0;
    te = ce ? l.tag_err : 4'h0; // checking off hides every error
    de = ce ? l.data_err : 4'h0;
    cl = l.hit & ~te;
    h = |(cl & ~de);
    fx = (pol == 1 && dt == 1) ? te & l.tag_single : 4'h0; // parity never repairs
    case (l.op)
      icache_err_pkg::OP_FETCH: if (!l.cacheable) s = !h;
      else if (pol == 0) m = |te || |(l.hit & de);
      else if (|te) begin
        iv = te & ~fx;
        m = |(iv & l.lock); // a locked line was lost
        rl = !m;
      end
      icache_err_pkg::OP_TOUCH: n = |te || |(l.hit & de);
      icache_err_pkg::OP_LINE_INV: if (pol == 1 && |te) begin
        iv = te & ~fx & ~l.lock; // correction cycle first, hits handled on re-lookup
        rl = 1'h1;
      end else iv = cl | (l.hit & te & ~l.lock);
      default: if (!(|cl)) begin
        if (pol == 1) iv = te & ~fx;
        if (l.op == icache_err_pkg::OP_TOUCH_LOCK) m = pol == 1 ? |(iv & l.lock) : |te;
        else m = pol == 1 ? |(iv & (l.lock | l.lock_err)) : |(te & l.lock);
      end else if (pol == 1) iv = te & ~fx & ~l.lock;
    endcase
    return {m, rl, n, s, h, iv, fx};
  endfunction
  // one lookup, masked compare; a plain refill is completed cleanly
  task automatic run(input logic [2:0] o, input logic c, input logic [23:0] w,
    input logic [12:0] k);
    p.send({o, c, w}, a);
    chk("act", {a.mchk, a.relookup, a.nop, a.single_beat, a.serve_hit, a.inval, a.fix} & k,
      model({o, c, w}) & k);
    chk("act_valid", a.valid, 1'h1);
    if (a.refill && !a.refill_keep) p.fill(1, 1'h0, b);
  endtask
  // policy write, remembered for the model
  task automatic cfg(input int pa, input int ty, input int en);
    {pol, dt, ce} = {pa, ty, en};
    bus(1'h1, 8'h00, {27'h0, 1'(en), 2'(ty), 2'(pa)});
    chk("bresp", r, 2'h0);
  endtask
  // main sequence
  initial begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    seed = 8'h17;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'h1;
    bus(1'h0, 8'h00, 32'h0);
    chk("csr1_rst", d, 32'h0);
    bus(1'h0, 8'h0C, 32'h0);
    chk("rresp_unmapped", r, 2'h2);
    bus(1'h1, 8'h0C, 32'h0);
    chk("bresp_unmapped", r, 2'h2);
    $display("test registers done");
    cfg(0, 0, 0);
    run(3'h0, 1'h1, 24'h020001, 13'h1CF0);
    cfg(0, 0, 1);
    run(3'h0, 1'h1, 24'h020000, 13'h1DFF);
    run(3'h0, 1'h1, 24'h100001, 13'h1DFF);
    run(3'h0, 1'h0, 24'h010000, 13'h1FFF);
    run(3'h0, 1'h0, 24'h220000, 13'h1FFF);
    run(3'h0, 1'h0, 24'h400000, 13'h1FFF);
    run(3'h1, 1'h1, 24'h110000, 13'h1CF0);
    run(3'h2, 1'h1, 24'h330200, 13'h1CF0);
    run(3'h3, 1'h1, 24'h010000, 13'h1CF0);
    run(3'h3, 1'h1, 24'h120000, 13'h1CF0);
    chk("lock_set", a.lock_set, 4'h1);
    run(3'h4, 1'h1, 24'h010000, 13'h1CF0);
    run(3'h4, 1'h1, 24'h010100, 13'h1CF0);
    $display("test machine-check policy done");
    cfg(1, 1, 1);
    bus(1'h0, 8'h00, 32'h0);
    chk("csr1", d, 32'h00000015);
    run(3'h0, 1'h1, 24'h031000, 13'h1CFF);
    run(3'h0, 1'h1, 24'h040400, 13'h18F0);
    run(3'h2, 1'h1, 24'h031200, 13'h1CFF);
    run(3'h4, 1'h1, 24'h020020, 13'h1CF0);
    run(3'h3, 1'h1, 24'h160400, 13'h1CF0);
    seed = lfsr(seed);
    run(3'h0, 1'h1, {4'h2, 16'h0000, seed[3:0] & 4'hD}, 13'h1FFF);
    bus(1'h1, 8'h04, 32'h02000003); // pointer loaded with way 2
    run(3'h0, 1'h1, 24'h100101, 13'h1000);
    chk("refill_keep", {a.refill, a.refill_keep, a.refill_way}, 4'hC);
    p.fill(2, 1'h1, b);
    chk("fill_err", {b.mchk, b.inval}, 5'h11);
    chk("ptr_held", repl_ptr, 2'h2);
    bus(1'h0, 8'h08, 32'h0);
    chk("status", d, 32'h00000023);
    bus(1'h1, 8'h08, 32'h00000003);
    bus(1'h0, 8'h08, 32'h0);
    chk("status_w1c", d, 32'h00000020);
    cfg(1, 0, 1);
    run(3'h0, 1'h1, 24'h031000, 13'h1CFF);
    $display("test correction policy done");
    repeat (3) begin
      seed = lfsr(seed);
      swq.push_back(seed);
      bus(1'h1, 8'h04, {6'h00, seed[1:0], 13'h0000, seed[7:2], 5'h00});
      chk("swinv", sv, 1'h1);
      chk("swinv_sel", sw, swq.pop_front());
      chk("swinv_quiet", act.valid, 1'h0);
    end
    $display("test set/way invalidate done");
    final_report();
  end
  // cut a hang short
  initial begin
    repeat (16'h1388) @(posedge ref_clk);
    n_mismatch++;
    final_report();
  end
endmodule
